// ---- verilog/rlcb_regs.sv ----
// module: configuration, group and brightness register file with per-module level selection
module rlcb_regs (
  input  wire logic                          clk_sys,
  input  wire logic                          resetn,
  input  wire logic                          wr_en,
  input  wire logic                          rd_en,
  input  wire logic [rlcb_pkg::ADDR_W-1:0]   addr,
  input  wire logic [rlcb_pkg::DATA_W-1:0]   wr_data,
  output logic      [rlcb_pkg::DATA_W-1:0]   rd_data_q,
  output logic                               chip_en,
  output logic                               all_outputs_off,
  output logic                               max_current_sel,
  output logic                               dither_en,
  output logic                               power_save_en,
  output logic                               log_scale_en,
  output logic                               phase_shift_en,
  output logic      [rlcb_pkg::MODULES-1:0]  module_group_sel,
  output logic      [rlcb_pkg::MODULES*8-1:0] module_brightness,
  output logic      [rlcb_pkg::MODULES*8-1:0] module_red_level,
  output logic      [rlcb_pkg::MODULES*8-1:0] module_green_level,
  output logic      [rlcb_pkg::MODULES*8-1:0] module_blue_level
);
  localparam int unsigned N = rlcb_pkg::MODULES;

  logic       soft_clr;
  logic [7:0] enable_cfg_q;
  logic [7:0] option_cfg_q;
  logic [7:0] sel_lo_q;
  logic [7:0] sel_hi_q;
  logic [7:0] group_brt_q;
  logic [7:0] group_a_q;
  logic [7:0] group_b_q;
  logic [7:0] group_c_q;
  logic [7:0] brt_q   [N];
  logic [7:0] red_q   [N];
  logic [7:0] green_q [N];
  logic [7:0] blue_q  [N];
  logic [7:0] rd_data_d;

  // ----------------------------------------------------------------------------
  // soft reset: the write itself stores nothing, the register reads back zero
  // ----------------------------------------------------------------------------
  assign soft_clr = wr_en && (addr == rlcb_pkg::OFS_SOFT_RESET) && (wr_data == rlcb_pkg::SOFT_RESET_KEY);

  // ----------------------------------------------------------------------------
  // configuration and group registers
  // ----------------------------------------------------------------------------
  rlcb_reg8 #(
    .RESET_VALUE (rlcb_pkg::RST_ENABLE_CFG),
    .WRITE_MASK  (rlcb_pkg::MASK_ENABLE_CFG)
  ) u_enable_cfg (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .soft_clr (soft_clr),
    .wr_en    (wr_en && addr == rlcb_pkg::OFS_ENABLE_CFG),
    .wr_data  (wr_data),
    .value_q  (enable_cfg_q)
  );

  rlcb_reg8 #(
    .RESET_VALUE (rlcb_pkg::RST_OPTION_CFG),
    .WRITE_MASK  (8'hff)
  ) u_option_cfg (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .soft_clr (soft_clr),
    .wr_en    (wr_en && addr == rlcb_pkg::OFS_OPTION_CFG),
    .wr_data  (wr_data),
    .value_q  (option_cfg_q)
  );

  rlcb_reg8 #(
    .RESET_VALUE (rlcb_pkg::RST_SEL),
    .WRITE_MASK  (8'hff)
  ) u_sel_lo (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .soft_clr (soft_clr),
    .wr_en    (wr_en && addr == rlcb_pkg::OFS_SEL_LO),
    .wr_data  (wr_data),
    .value_q  (sel_lo_q)
  );

  rlcb_reg8 #(
    .RESET_VALUE (rlcb_pkg::RST_SEL),
    .WRITE_MASK  (rlcb_pkg::MASK_SEL_HI)
  ) u_sel_hi (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .soft_clr (soft_clr),
    .wr_en    (wr_en && addr == rlcb_pkg::OFS_SEL_HI),
    .wr_data  (wr_data),
    .value_q  (sel_hi_q)
  );

  rlcb_reg8 #(
    .RESET_VALUE (rlcb_pkg::RST_GROUP_BRT),
    .WRITE_MASK  (8'hff)
  ) u_group_brt (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .soft_clr (soft_clr),
    .wr_en    (wr_en && addr == rlcb_pkg::OFS_GROUP_BRT),
    .wr_data  (wr_data),
    .value_q  (group_brt_q)
  );

  rlcb_reg8 #(
    .RESET_VALUE (rlcb_pkg::RST_GROUP_MIX),
    .WRITE_MASK  (8'hff)
  ) u_group_a (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .soft_clr (soft_clr),
    .wr_en    (wr_en && addr == rlcb_pkg::OFS_GROUP_A),
    .wr_data  (wr_data),
    .value_q  (group_a_q)
  );

  rlcb_reg8 #(
    .RESET_VALUE (rlcb_pkg::RST_GROUP_MIX),
    .WRITE_MASK  (8'hff)
  ) u_group_b (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .soft_clr (soft_clr),
    .wr_en    (wr_en && addr == rlcb_pkg::OFS_GROUP_B),
    .wr_data  (wr_data),
    .value_q  (group_b_q)
  );

  rlcb_reg8 #(
    .RESET_VALUE (rlcb_pkg::RST_GROUP_MIX),
    .WRITE_MASK  (8'hff)
  ) u_group_c (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .soft_clr (soft_clr),
    .wr_en    (wr_en && addr == rlcb_pkg::OFS_GROUP_C),
    .wr_data  (wr_data),
    .value_q  (group_c_q)
  );

  // ----------------------------------------------------------------------------
  // per-module brightness and colour mixing
  // ----------------------------------------------------------------------------
  for (genvar m = 0; m < N; m++)
  begin : g_module
    rlcb_reg8 #(
      .RESET_VALUE (rlcb_pkg::RST_MOD_BRT),
      .WRITE_MASK  (8'hff)
    ) u_brt (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .soft_clr (soft_clr),
      .wr_en    (wr_en && addr == rlcb_pkg::OFS_MOD_BRT + 8'(m)),
      .wr_data  (wr_data),
      .value_q  (brt_q[m])
    );

    rlcb_reg8 #(
      .RESET_VALUE (rlcb_pkg::RST_MIX),
      .WRITE_MASK  (8'hff)
    ) u_red (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .soft_clr (soft_clr),
      .wr_en    (wr_en && addr == rlcb_pkg::OFS_RED_MIX + 8'(m)),
      .wr_data  (wr_data),
      .value_q  (red_q[m])
    );

    rlcb_reg8 #(
      .RESET_VALUE (rlcb_pkg::RST_MIX),
      .WRITE_MASK  (8'hff)
    ) u_green (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .soft_clr (soft_clr),
      .wr_en    (wr_en && addr == rlcb_pkg::OFS_GREEN_MIX + 8'(m)),
      .wr_data  (wr_data),
      .value_q  (green_q[m])
    );

    rlcb_reg8 #(
      .RESET_VALUE (rlcb_pkg::RST_MIX),
      .WRITE_MASK  (8'hff)
    ) u_blue (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .soft_clr (soft_clr),
      .wr_en    (wr_en && addr == rlcb_pkg::OFS_BLUE_MIX + 8'(m)),
      .wr_data  (wr_data),
      .value_q  (blue_q[m])
    );

    // levels are the raw codes, registered from the group registers when the module's select bit is set
    always_ff @(posedge clk_sys or negedge resetn)
    begin
      if (!resetn)
      begin
        module_brightness[m*8 +: 8]  <= rlcb_pkg::RST_MOD_BRT;
        module_red_level[m*8 +: 8]   <= rlcb_pkg::RST_MIX;
        module_green_level[m*8 +: 8] <= rlcb_pkg::RST_MIX;
        module_blue_level[m*8 +: 8]  <= rlcb_pkg::RST_MIX;
      end
      else if (module_group_sel[m])
      begin
        module_brightness[m*8 +: 8]  <= group_brt_q;
        module_red_level[m*8 +: 8]   <= group_a_q;
        module_green_level[m*8 +: 8] <= group_b_q;
        module_blue_level[m*8 +: 8]  <= group_c_q;
      end
      else
      begin
        module_brightness[m*8 +: 8]  <= brt_q[m];
        module_red_level[m*8 +: 8]   <= red_q[m];
        module_green_level[m*8 +: 8] <= green_q[m];
        module_blue_level[m*8 +: 8]  <= blue_q[m];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // decoded controls
  // ----------------------------------------------------------------------------
  assign chip_en          = enable_cfg_q[rlcb_pkg::BIT_CHIP_EN];
  assign all_outputs_off  = option_cfg_q[rlcb_pkg::BIT_ALL_OFF];
  assign max_current_sel  = option_cfg_q[rlcb_pkg::BIT_MAX_CURRENT];
  assign dither_en        = option_cfg_q[rlcb_pkg::BIT_DITHER];
  assign power_save_en    = option_cfg_q[rlcb_pkg::BIT_POWER_SAVE];
  assign log_scale_en     = option_cfg_q[rlcb_pkg::BIT_LOG_SCALE];
  assign phase_shift_en   = option_cfg_q[rlcb_pkg::BIT_PHASE_SHIFT];
  assign module_group_sel = {sel_hi_q[3:0], sel_lo_q};

  // ----------------------------------------------------------------------------
  // read path: unmapped and write-only offsets read zero
  // ----------------------------------------------------------------------------
  always_comb
  begin
    rd_data_d = 8'h00;
    if (addr == rlcb_pkg::OFS_ENABLE_CFG)
      rd_data_d = enable_cfg_q;
    else if (addr == rlcb_pkg::OFS_OPTION_CFG)
      rd_data_d = option_cfg_q;
    else if (addr == rlcb_pkg::OFS_SEL_LO)
      rd_data_d = sel_lo_q;
    else if (addr == rlcb_pkg::OFS_SEL_HI)
      rd_data_d = sel_hi_q;
    else if (addr == rlcb_pkg::OFS_GROUP_BRT)
      rd_data_d = group_brt_q;
    else if (addr == rlcb_pkg::OFS_GROUP_A)
      rd_data_d = group_a_q;
    else if (addr == rlcb_pkg::OFS_GROUP_B)
      rd_data_d = group_b_q;
    else if (addr == rlcb_pkg::OFS_GROUP_C)
      rd_data_d = group_c_q;
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        if (addr == rlcb_pkg::OFS_MOD_BRT + 8'(i))
          rd_data_d = brt_q[i];
        if (addr == rlcb_pkg::OFS_RED_MIX + 8'(i))
          rd_data_d = red_q[i];
        if (addr == rlcb_pkg::OFS_GREEN_MIX + 8'(i))
          rd_data_d = green_q[i];
        if (addr == rlcb_pkg::OFS_BLUE_MIX + 8'(i))
          rd_data_d = blue_q[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rd_data_q <= 8'h00;
    else if (rd_en)
      rd_data_q <= rd_data_d;
  end
endmodule // rlcb_regs

// ---- verilog/rlcb_pkg.sv ----
// package: offsets, field positions, reset values and widths of the configuration and brightness register file
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package rlcb_pkg;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned MODULES   = 12;
  localparam int unsigned COLOURS   = 3;

  // ----------------------------------------------------------------------------
  // offsets
  // ----------------------------------------------------------------------------
  localparam logic [7:0] OFS_ENABLE_CFG  = 8'h00;
  localparam logic [7:0] OFS_OPTION_CFG  = 8'h01;
  localparam logic [7:0] OFS_SEL_LO      = 8'h02;
  localparam logic [7:0] OFS_SEL_HI      = 8'h03;
  localparam logic [7:0] OFS_GROUP_BRT   = 8'h04;
  localparam logic [7:0] OFS_GROUP_A     = 8'h05;
  localparam logic [7:0] OFS_GROUP_B     = 8'h06;
  localparam logic [7:0] OFS_GROUP_C     = 8'h07;
  localparam logic [7:0] OFS_MOD_BRT     = 8'h08;
  localparam logic [7:0] OFS_MOD_BRT_END = 8'h13;
  localparam logic [7:0] OFS_RED_MIX     = 8'h14;
  localparam logic [7:0] OFS_GREEN_MIX   = 8'h20;
  localparam logic [7:0] OFS_BLUE_MIX    = 8'h2c;
  localparam logic [7:0] OFS_MIX_END     = 8'h37;
  localparam logic [7:0] OFS_SOFT_RESET  = 8'h38;

  // ----------------------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------------------
  localparam int unsigned BIT_CHIP_EN     = 6;
  localparam int unsigned BIT_ALL_OFF     = 0;
  localparam int unsigned BIT_MAX_CURRENT = 1;
  localparam int unsigned BIT_DITHER      = 2;
  localparam int unsigned BIT_POWER_SAVE  = 4;
  localparam int unsigned BIT_LOG_SCALE   = 5;
  localparam int unsigned BIT_PHASE_SHIFT = 7;
  localparam logic [7:0] MASK_ENABLE_CFG  = 8'h40;
  localparam logic [7:0] MASK_SEL_HI      = 8'h0f;
  localparam logic [7:0] RST_ENABLE_CFG   = 8'h00;
  localparam logic [7:0] RST_OPTION_CFG   = 8'hae;
  localparam logic [7:0] RST_SEL          = 8'h00;
  localparam logic [7:0] RST_GROUP_BRT    = 8'hff;
  localparam logic [7:0] RST_GROUP_MIX    = 8'h00;
  localparam logic [7:0] RST_MOD_BRT      = 8'hff;
  localparam logic [7:0] RST_MIX          = 8'h00;
  localparam logic [7:0] SOFT_RESET_KEY   = 8'hff;
endpackage : rlcb_pkg

// ---- verilog/rlcb_reg8.sv ----
// module: one eight-bit read/write register with write mask and soft default
module rlcb_reg8 #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK  = 8'hff
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       soft_clr,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] value_q
);
  // ----------------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      value_q <= RESET_VALUE;
    else if (soft_clr)
      value_q <= RESET_VALUE;
    else if (wr_en)
      value_q <= wr_data & WRITE_MASK; // masked bits stay zero
  end
endmodule // rlcb_reg8

// ---- verif/rlcb_regs_props.sv ----
// checker: port-level relations of the register file
module rlcb_regs_props (
  input wire logic                           clk_sys,
  input wire logic                           resetn,
  input wire logic                           wr_en,
  input wire logic                           rd_en,
  input wire logic [rlcb_pkg::ADDR_W-1:0]    addr,
  input wire logic [rlcb_pkg::DATA_W-1:0]    wr_data,
  input wire logic [rlcb_pkg::DATA_W-1:0]    rd_data_q,
  input wire logic                           chip_en,
  input wire logic                           all_outputs_off,
  input wire logic                           max_current_sel,
  input wire logic                           dither_en,
  input wire logic                           power_save_en,
  input wire logic                           log_scale_en,
  input wire logic                           phase_shift_en,
  input wire logic [rlcb_pkg::MODULES-1:0]   module_group_sel,
  input wire logic [rlcb_pkg::MODULES*8-1:0] module_brightness,
  input wire logic [rlcb_pkg::MODULES*8-1:0] module_red_level,
  input wire logic [rlcb_pkg::MODULES*8-1:0] module_green_level,
  input wire logic [rlcb_pkg::MODULES*8-1:0] module_blue_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  // bits 6 and 3 have no output, so they are masked out of every option compare
  logic [7:0] opt_v;
  assign opt_v = {phase_shift_en, 1'b0, log_scale_en, power_save_en, 1'b0, dither_en, max_current_sel, all_outputs_off};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence soft_rst_wr;
    wr_en && addr == 8'h38 && wr_data == 8'hff;
  endsequence
  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  AST_CHIP_EN: assert property (wr_en && addr == 8'h00 |=> chip_en == $past(wr_data[6]))
    else $error("chip enable does not follow the write");
  AST_OPT_WR: assert property (wr_en && addr == 8'h01 |=> opt_v == ($past(wr_data) & 8'hb7))
    else $error("option outputs do not follow the write");
  AST_SEL_LO: assert property (wr_en && addr == 8'h02 |=> module_group_sel[7:0] == $past(wr_data))
    else $error("low group select does not follow the write");
  AST_SEL_HI: assert property (wr_en && addr == 8'h03 |=> module_group_sel[11:8] == $past(wr_data[3:0]))
    else $error("high group select does not follow the write");
  AST_SOFT_DFLT: assert property (soft_rst_wr |=> !chip_en && module_group_sel == 12'h000 && opt_v == 8'ha6)
    else $error("soft reset left a control off its default");
  AST_SOFT_LVL: assert property (soft_rst_wr |-> ##2 module_brightness == {12{8'hff}}
    && module_red_level == 96'h0 && module_green_level == 96'h0 && module_blue_level == 96'h0)
    else $error("soft reset left a module level off its default");
  AST_RD_OPT: assert property (rd_en && addr == 8'h01 |=> (rd_data_q & 8'hb7) == $past(opt_v))
    else $error("option read differs from the outputs");
  AST_RD_CFG0: assert property (rd_en && addr == 8'h00 |=> rd_data_q == {1'b0, $past(chip_en), 6'h00})
    else $error("enable register read is wrong");
  AST_RD_UNMAP: assert property (rd_en && addr >= 8'h38 |=> rd_data_q == 8'h00)
    else $error("unmapped read is not zero");
  AST_RD_HOLD: assert property (!rd_en |=> $stable(rd_data_q))
    else $error("read data moved without a read");
endmodule // rlcb_regs_props

// ---- verif/rlcb_host.sv ----
// partner: host side of the byte access port
module rlcb_host (
  input wire logic       clk_sys,
  input wire logic [7:0] rd_data_q,
  output logic           wr_en,
  output logic           rd_en,
  output logic     [7:0] addr,
  output logic     [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
  end
  // released lines show the inverse so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge clk_sys);
    wr_en = 1'b0;
    addr = ~a;
    wr_data = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk_sys);
    rd_en = 1'b0;
    addr = ~a;
    d = rd_data_q;
  endtask
endmodule // rlcb_host

// ---- verif/rlcb_regs_tb.sv ----
// testbench: register file reset values, access, grouping and soft reset
module rlcb_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, resetn, wr_en, rd_en, chip_en, all_outputs_off, max_current_sel;
  logic        dither_en, power_save_en, log_scale_en, phase_shift_en;
  logic [7:0]  addr, wr_data, rd_data_q;
  logic [11:0] module_group_sel;
  logic [95:0] module_brightness, module_red_level, module_green_level, module_blue_level;
  int          n_fail, n_checks;
  // ----------------------------------------------------------------------------
  // instances and tasks
  // ----------------------------------------------------------------------------
  rlcb_host rlcb_host_inst (.clk_sys(clk_sys), .rd_data_q(rd_data_q), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data));
  rlcb_regs rlcb_regs_inst (.clk_sys(clk_sys), .resetn(resetn), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .rd_data_q(rd_data_q), .chip_en(chip_en), .all_outputs_off(all_outputs_off),
    .max_current_sel(max_current_sel), .dither_en(dither_en), .power_save_en(power_save_en),
    .log_scale_en(log_scale_en), .phase_shift_en(phase_shift_en), .module_group_sel(module_group_sel),
    .module_brightness(module_brightness), .module_red_level(module_red_level),
    .module_green_level(module_green_level), .module_blue_level(module_blue_level));
  task automatic stop_test();
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rlcb_host_inst.rd(a, d);
    chk(96'(d), 96'(e));
  endtask
  // every offset up to two past the soft reset register, plus the top of the map
  task automatic check_defaults();
    for (int a = 0; a <= 8'h3a; a++)
      rdchk(8'(a), (a == 1) ? 8'hae : (a == 4 || (a >= 8 && a <= 8'h13)) ? 8'hff : 8'h00);
    rdchk(8'hff, 8'h00);
    chk(96'({chip_en, all_outputs_off, max_current_sel, dither_en, power_save_en, log_scale_en, phase_shift_en}),
      96'h1b);
    chk(96'(module_group_sel), 96'h0);
    chk(module_brightness, {12{8'hff}});
    chk(module_red_level | module_green_level | module_blue_level, 96'h0);
  endtask
  // ----------------------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    stop_test();
  end
  initial
  begin
    logic [7:0] v;
    n_fail = 0;
    n_checks = 0;
    resetn = 1'b0;
    repeat (20) @(negedge clk_sys);
    resetn = 1'b1;
    check_defaults();
    rlcb_host_inst.wr(8'h00, 8'hff);
    rdchk(8'h00, 8'h40);
    chk(96'(chip_en), 96'h1);
    // one option bit at a time, bit 3 read back to show it is writable, then all clear
    for (int i = 0; i <= 8; i++)
    begin
      v = (i == 8) ? 8'h00 : 8'(8'h01 << i);
      rlcb_host_inst.wr(8'h01, v);
      chk(96'({phase_shift_en, log_scale_en, power_save_en, dither_en, max_current_sel, all_outputs_off}),
        96'({v[7], v[5], v[4], v[2], v[1], v[0]}));
      rdchk(8'h01, v);
    end
    rlcb_host_inst.wr(8'h01, 8'hae);
    rlcb_host_inst.wr(8'h02, 8'ha5);
    rlcb_host_inst.wr(8'h03, 8'hff);
    chk(96'(module_group_sel), 96'hfa5);
    rdchk(8'h03, 8'h0f);
    for (int a = 4; a <= 8'h37; a++)
      rlcb_host_inst.wr(8'(a), 8'(a) ^ 8'h5a);
    for (int a = 4; a <= 8'h37; a++)
      rdchk(8'(a), 8'(a) ^ 8'h5a);
    // module 0 grouped, module 1 on its own registers
    chk(96'(module_brightness[15:0]), 96'({8'h09 ^ 8'h5a, 8'h04 ^ 8'h5a}));
    chk(96'(module_red_level[15:0]), 96'({8'h15 ^ 8'h5a, 8'h05 ^ 8'h5a}));
    chk(96'(module_green_level[15:0]), 96'({8'h21 ^ 8'h5a, 8'h06 ^ 8'h5a}));
    chk(96'(module_blue_level[15:0]), 96'({8'h2d ^ 8'h5a, 8'h07 ^ 8'h5a}));
    rlcb_host_inst.wr(8'h02, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk(96'({module_brightness[7:0], module_red_level[7:0], module_green_level[7:0], module_blue_level[7:0]}),
      96'({8'h52, 8'h4e, 8'h7a, 8'h76}));
    // full scale and mid scale pass through unchanged
    rlcb_host_inst.wr(8'h08, 8'h80);
    rlcb_host_inst.wr(8'h14, 8'hff);
    repeat (2) @(negedge clk_sys);
    chk(96'({module_brightness[7:0], module_red_level[7:0]}), 96'h80ff);
    rlcb_host_inst.wr(8'h38, 8'h80);
    rdchk(8'h03, 8'h0f);
    rlcb_host_inst.wr(8'h38, 8'hff);
    check_defaults();
    stop_test();
  end
endmodule // rlcb_regs_tb
bind rlcb_regs rlcb_regs_props rlcb_regs_props_inst (.clk_sys(clk_sys), .resetn(resetn), .wr_en(wr_en),
  .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data_q(rd_data_q), .chip_en(chip_en),
  .all_outputs_off(all_outputs_off), .max_current_sel(max_current_sel), .dither_en(dither_en),
  .power_save_en(power_save_en), .log_scale_en(log_scale_en), .phase_shift_en(phase_shift_en),
  .module_group_sel(module_group_sel), .module_brightness(module_brightness), .module_red_level(module_red_level),
  .module_green_level(module_green_level), .module_blue_level(module_blue_level));
